// File: hw/mmd_pkg.sv
/*
 package for the memory map decoder and internal ram allocator.
 assumes 32-bit bus addresses and six bus matrix masters.
*/
package mmd_pkg;
	// ==========================================================
	// sizes
	localparam int ADDR_W = 32;
	localparam int NUM_MASTERS = 6;
	localparam int MID_W = 3;
	localparam int NUM_BLOCKS = 4;
	localparam int BLK_AW = 14;
	localparam int BANK_W = 4;
	localparam int ICS_W = 6;
	// ==========================================================
	// bank numbers
	localparam logic [3:0] BANK_INTERNAL = 4'h0;
	localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
	localparam logic [3:0] BANK_EXT_LAST = 4'h8;
	localparam logic [3:0] BANK_PERIPH = 4'hF;
	// ==========================================================
	// internal 1 MB window numbers, address bits 27:20 of bank zero
	localparam logic [7:0] WIN_BOOT = 8'h00;
	localparam logic [7:0] WIN_INSTRUCTION_COUPLED_RAM = 8'h01;
	localparam logic [7:0] WIN_DATA_COUPLED_RAM = 8'h02;
	localparam logic [7:0] WIN_SHARED = 8'h03;
	localparam logic [7:0] WIN_ROM = 8'h04;
	localparam int ROM_BYTES = 32768;
	// ==========================================================
	// master numbers
	localparam logic [2:0] MID_CPU_INSTR = 3'h4;
	localparam logic [2:0] MID_CPU_DATA = 3'h5;
	// ==========================================================
	// chip select layout for external banks
	localparam int EXT_CS_BANKS = 6;
	// ==========================================================
	// tcm size codes
	typedef enum logic [1:0] {
		MMD_TCM_0K,
		MMD_TCM_16K,
		MMD_TCM_32K
	} mmd_tcm_size_t;
	typedef enum logic [2:0] {
		MMD_SLV_NONE,
		MMD_SLV_ROM,
		MMD_SLV_SRAM,
		MMD_SLV_EXT,
		MMD_SLV_PERIPH,
		MMD_SLV_ERROR
	} mmd_slave_t;
endpackage

// File: hw/mmd_alloc_if.sv
/*
 carries tcm sizes and block lookups between the decoder and the
 ram block allocator. assumes a single clock domain.
*/
`timescale 1ns/1ps
interface mmd_alloc_if;
	import mmd_pkg::*;
	logic [1:0] instruction_coupled_ram_size;
	logic [1:0] data_coupled_ram_size;
	logic [1:0] region;
	logic [1:0] slot;
	logic hit;
	logic [1:0] block;
	modport decoder (output instruction_coupled_ram_size, data_coupled_ram_size, region, slot,
		input hit, block);
	modport alloc (input instruction_coupled_ram_size, data_coupled_ram_size, region, slot,
		output hit, block);
endinterface

// File: hw/mmd_block_alloc.sv
/*
 ram block allocator: maps a region and 16 KB slot to a physical
 block. assumes sizes come from registered configuration.
*/
`timescale 1ns/1ps
module mmd_block_alloc
(
	// lookup
	mmd_alloc_if.alloc al
);
	import mmd_pkg::*;
	logic [2:0] icnt;
	logic [2:0] dcnt;
	logic [2:0] scnt;
	// ==========================================================
	// block lookup
	always_comb
	begin
		icnt = (al.instruction_coupled_ram_size == MMD_TCM_32K) ? 3'h2 :
			(al.instruction_coupled_ram_size == MMD_TCM_16K) ? 3'h1 : 3'h0;
		dcnt = (al.data_coupled_ram_size == MMD_TCM_32K) ? 3'h2 :
			(al.data_coupled_ram_size == MMD_TCM_16K) ? 3'h1 : 3'h0;
		scnt = 3'h4 - icnt - dcnt; // [R14]
		al.hit = 1'b0;
		al.block = 2'h0;
		case (al.region)
			2'h0:
			begin
				// instruction: block 1 then block 0
				al.hit = {1'b0, al.slot} < icnt; // [R16]
				al.block = 2'h1 - al.slot;
			end
			2'h1:
			begin
				// data: block 3 then block 2
				al.hit = {1'b0, al.slot} < dcnt; // [R16]
				al.block = 2'h3 - al.slot;
			end
			2'h2:
			begin
				// shared: free data blocks first, then free instr blocks
				al.hit = {1'b0, al.slot} < scnt; // [R16]
				if ({1'b0, al.slot} < 3'h2 - dcnt)
					al.block = 2'(3'h3 - dcnt - {1'b0, al.slot});
				else
					al.block = 2'(3'h3 - dcnt - icnt - {1'b0, al.slot}); // [R16]
			end
			default:
			begin
				al.hit = 1'b0;
				al.block = 2'h0;
			end
		endcase
	end
endmodule

// File: hw/mmd_decoder.sv
/*
 memory map decoder with boot alias and internal ram allocation.
 assumes one request per cycle from the bus matrix, on clock_i,
 with a boot select pin from outside the clock domain.
*/
// Behaviour
// R1: sixteen 256 MB banks chosen by address bits 31:28.
// R2: banks one to eight go to the external bus interface.
// R3: bank zero holds on-chip memories, decoded into 1 MB windows.
// R4: bank fifteen goes to the peripheral bridge.
// R5: unused banks reach no slave and return an error.
// R6: address zero shows rom, chip select zero or ram per remap.
// R7: one remap bit per bus matrix master.
// R8: boot memory on chip select zero is 16-bit non-volatile.
// R9: shared ram at 0x0030_0000, at zero too after remap.
// R10: instruction tcm ram also seen on the bus at 0x0010_0000.
// R11: data tcm ram also seen on the bus at 0x0020_0000.
// R12: shared ram reachable only through the bus matrix.
// R13: zero alias of shared ram only for cpu masters.
// R14: four 16 KB blocks; tcm sizes 0, 16 or 32 KB each.
// R15: after reset both tcm sizes are zero.
// R16: fixed block placement for tcm and shared regions.
// R17: instruction tcm relocatable via coprocessor and config reg.
// R18: bus ram access completes in one master clock cycle.
// R19: tcm port ram access completes in one cycle.
// R20: boot select pin sampled at reset chooses rom or cs zero.
// R21: rom always at 0x0040_0000.
// R22: unmapped internal addresses return an error.
// R23: remap bits reset to zero.
`timescale 1ns/1ps
module mmd_decoder
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// boot strap pin
	input wire logic boot_select_pin_i,
	// configuration
	input wire logic [mmd_pkg::NUM_MASTERS-1:0] remap_set_i,
	input wire logic [mmd_pkg::NUM_MASTERS-1:0] remap_clr_i,
	input wire logic cfg_wr_i,
	input wire logic [1:0] instruction_coupled_ram_size_i,
	input wire logic [1:0] data_coupled_ram_size_i,
	input wire logic [31:0] instruction_coupled_ram_base_i,
	// bus request
	input wire logic req_valid_i,
	input wire logic [mmd_pkg::MID_W-1:0] req_master_i,
	input wire logic [mmd_pkg::ADDR_W-1:0] req_addr_i,
	// tcm request from the processor
	input wire logic tcm_valid_i,
	input wire logic tcm_instr_i,
	input wire logic [31:0] tcm_addr_i,
	// bus decode result
	output logic rsp_valid_o,
	output mmd_pkg::mmd_slave_t rsp_slave_o,
	output logic rsp_error_o,
	output logic [mmd_pkg::ICS_W-1:0] ext_cs_o,
	output logic [27:0] rsp_offset_o,
	output logic [1:0] rsp_block_o,
	// tcm decode result
	output logic tcm_rsp_valid_o,
	output logic tcm_hit_o,
	output logic [1:0] tcm_block_o,
	// status
	output logic [mmd_pkg::NUM_MASTERS-1:0] remap_o,
	output logic boot_rom_o,
	output logic [1:0] instruction_coupled_ram_size_o,
	output logic [1:0] data_coupled_ram_size_o
);
	import mmd_pkg::*;
	logic boot_meta_q;
	logic boot_sync_q;
	logic boot_taken_q;
	logic boot_rom_q;
	logic [NUM_MASTERS-1:0] remap_q;
	logic [1:0] instruction_coupled_ram_q;
	logic [1:0] data_coupled_ram_q;
	logic [31:0] instruction_coupled_ram_base_q;
	logic rsp_valid_q;
	mmd_slave_t slave_d;
	mmd_slave_t slave_q;
	logic [ICS_W-1:0] cs_d;
	logic [ICS_W-1:0] cs_q;
	logic [27:0] off_d;
	logic [27:0] off_q;
	logic [1:0] blk_q;
	logic tcm_valid_q;
	logic tcm_hit_q;
	logic [1:0] tcm_blk_q;
	logic [3:0] bank;
	logic [7:0] win;
	logic [19:0] wofs;
	logic remap_me;
	logic cpu_master;
	logic err_q;
	logic sram_in;
	logic rom_in;
	logic [31:0] toff;
	logic tcm_in;
	mmd_alloc_if bus_al ();
	mmd_alloc_if tcm_al ();
	// ==========================================================
	// allocators
	mmd_block_alloc u_bus_alloc
	(
		.al(bus_al)
	);
	mmd_block_alloc u_tcm_alloc
	(
		.al(tcm_al)
	);
	// ==========================================================
	// boot pin synchroniser and strap capture
	always_ff @(posedge clock_i)
	begin
		boot_meta_q <= boot_select_pin_i;
		boot_sync_q <= boot_meta_q;
	end
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			boot_taken_q <= 1'b0;
			boot_rom_q <= 1'b1;
		end
		else if (!boot_taken_q)
		begin
			boot_taken_q <= 1'b1;
			boot_rom_q <= boot_sync_q; // [R20]
		end
	end
	// ==========================================================
	// per-master remap bits
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			remap_q <= '0; // [R23]
		else
			remap_q <= (remap_q & ~remap_clr_i) | remap_set_i; // [R7]
	end
	// ==========================================================
	// tcm configuration
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			instruction_coupled_ram_q <= MMD_TCM_0K; // [R15]
			data_coupled_ram_q <= MMD_TCM_0K; // [R15]
			instruction_coupled_ram_base_q <= '0;
		end
		else if (cfg_wr_i)
		begin
			instruction_coupled_ram_q <= (instruction_coupled_ram_size_i > MMD_TCM_32K) ? instruction_coupled_ram_q : instruction_coupled_ram_size_i;
			data_coupled_ram_q <= (data_coupled_ram_size_i > MMD_TCM_32K) ? data_coupled_ram_q : data_coupled_ram_size_i;
			instruction_coupled_ram_base_q <= instruction_coupled_ram_base_i; // [R17]
		end
	end
	// ==========================================================
	// bus address decode
	assign bank = req_addr_i[31:28];
	assign win = req_addr_i[27:20];
	assign wofs = req_addr_i[19:0];
	assign remap_me = remap_q[req_master_i];
	assign cpu_master = (req_master_i == MID_CPU_INSTR) ||
		(req_master_i == MID_CPU_DATA);
	assign bus_al.instruction_coupled_ram_size = instruction_coupled_ram_q;
	assign bus_al.data_coupled_ram_size = data_coupled_ram_q;
	assign bus_al.slot = wofs[BLK_AW+1:BLK_AW];
	// ==========================================================
	// window range checks
	assign sram_in = (wofs >> (BLK_AW + 2)) == '0;
	assign rom_in = wofs < 20'(ROM_BYTES);
	always_comb
	begin
		slave_d = MMD_SLV_ERROR; // [R5]
		cs_d = '0;
		off_d = req_addr_i[27:0];
		bus_al.region = 2'h3;
		if (bank == BANK_INTERNAL) // [R1] [R3]
		begin
			case (win)
				WIN_BOOT:
				begin
					if (remap_me && cpu_master) // [R6] [R13]
					begin
						bus_al.region = 2'h2; // [R9]
						slave_d = MMD_SLV_SRAM;
					end
					else if (!remap_me && boot_rom_q) // [R6]
					begin
						if (rom_in)
							slave_d = MMD_SLV_ROM; // [R22]
					end
					else if (!remap_me)
					begin
						slave_d = MMD_SLV_EXT; // [R6]
						cs_d = 6'h01;
					end
				end
				WIN_INSTRUCTION_COUPLED_RAM:
				begin
					bus_al.region = 2'h0; // [R10]
					slave_d = MMD_SLV_SRAM;
				end
				WIN_DATA_COUPLED_RAM:
				begin
					bus_al.region = 2'h1; // [R11]
					slave_d = MMD_SLV_SRAM;
				end
				WIN_SHARED:
				begin
					bus_al.region = 2'h2; // [R9] [R12]
					slave_d = MMD_SLV_SRAM;
				end
				WIN_ROM:
					if (rom_in)
						slave_d = MMD_SLV_ROM; // [R21]
				default:
					slave_d = MMD_SLV_ERROR; // [R22]
			endcase
			if (slave_d == MMD_SLV_SRAM && !(bus_al.hit && sram_in))
				slave_d = MMD_SLV_ERROR; // [R22]
			if (slave_d == MMD_SLV_ROM)
				off_d = {13'h0000, wofs[14:0]};
		end
		else if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_LAST)
		begin
			slave_d = MMD_SLV_EXT; // [R2]
			// banks past the last chip select drive no select line
			if (bank - BANK_EXT_FIRST < 4'(EXT_CS_BANKS))
				cs_d = 6'(6'h01 << (bank - BANK_EXT_FIRST));
		end
		else if (bank == BANK_PERIPH)
			slave_d = MMD_SLV_PERIPH; // [R4]
	end
	// ==========================================================
	// single-cycle bus result
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			rsp_valid_q <= 1'b0;
			slave_q <= MMD_SLV_NONE;
			cs_q <= '0;
			off_q <= '0;
			blk_q <= '0;
		end
		else
		begin
			rsp_valid_q <= req_valid_i; // [R18]
			slave_q <= req_valid_i ? slave_d : MMD_SLV_NONE;
			cs_q <= req_valid_i ? cs_d : '0;
			off_q <= req_valid_i ? off_d : '0;
			blk_q <= bus_al.block;
		end
	end
	// ==========================================================
	// error flag, registered so the output comes from a flop
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			err_q <= 1'b0;
		else
			err_q <= req_valid_i && slave_d == MMD_SLV_ERROR; // [R5]
	end
	// ==========================================================
	// tcm port decode
	assign toff = tcm_addr_i - (tcm_instr_i ? instruction_coupled_ram_base_q : 32'h0);
	assign tcm_in = toff[31:BLK_AW+1] == '0;
	assign tcm_al.instruction_coupled_ram_size = instruction_coupled_ram_q;
	assign tcm_al.data_coupled_ram_size = data_coupled_ram_q;
	assign tcm_al.region = tcm_instr_i ? 2'h0 : 2'h1; // [R12]
	assign tcm_al.slot = toff[BLK_AW+1:BLK_AW];
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			tcm_valid_q <= 1'b0;
			tcm_hit_q <= 1'b0;
			tcm_blk_q <= '0;
		end
		else
		begin
			tcm_valid_q <= tcm_valid_i; // [R19]
			tcm_hit_q <= tcm_valid_i && tcm_in && tcm_al.hit; // [R17]
			tcm_blk_q <= tcm_al.block;
		end
	end
	// ==========================================================
	// outputs
	assign rsp_valid_o = rsp_valid_q;
	assign rsp_slave_o = slave_q;
	assign rsp_error_o = err_q; // [R5]
	assign ext_cs_o = cs_q;
	assign rsp_offset_o = off_q;
	assign rsp_block_o = blk_q;
	assign tcm_rsp_valid_o = tcm_valid_q;
	assign tcm_hit_o = tcm_hit_q;
	assign tcm_block_o = tcm_blk_q;
	assign remap_o = remap_q;
	assign boot_rom_o = boot_rom_q;
	assign instruction_coupled_ram_size_o = instruction_coupled_ram_q;
	assign data_coupled_ram_size_o = data_coupled_ram_q;
endmodule

// File: dv/mmd_master_model.sv
/*
 bus matrix master model: holds a request while go is high.
 assumes the bench moves go, master and address at the falling edge.
*/
`timescale 1ns/1ps
module mmd_master_model
(
	// clock
	input wire logic clock_i,
	// bench side
	input wire logic go_i,
	input wire logic [2:0] mid_i,
	input wire logic [31:0] addr_i,
	// bus side
	output logic req_valid_o,
	output logic [2:0] req_master_o,
	output logic [31:0] req_addr_o
);
	logic [31:0] last_q;
	always_ff @(posedge clock_i)
	begin
		if (go_i)
			last_q <= addr_i;
	end
	// released address shows the inverse of the last one
	assign req_valid_o = go_i;
	assign req_master_o = mid_i;
	assign req_addr_o = go_i ? addr_i : ~last_q;
endmodule

// File: dv/mmd_decoder_checker.sv
/*
 assertions on the decoder top ports.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module mmd_decoder_checker
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// inputs
	input wire logic [mmd_pkg::NUM_MASTERS-1:0] remap_set_i,
	input wire logic req_valid_i,
	input wire logic [mmd_pkg::MID_W-1:0] req_master_i,
	input wire logic [mmd_pkg::ADDR_W-1:0] req_addr_i,
	// outputs
	input wire logic rsp_valid_o,
	input wire mmd_pkg::mmd_slave_t rsp_slave_o,
	input wire logic rsp_error_o,
	input wire logic [mmd_pkg::ICS_W-1:0] ext_cs_o,
	input wire logic [1:0] rsp_block_o,
	input wire logic [mmd_pkg::NUM_MASTERS-1:0] remap_o,
	input wire logic boot_rom_o,
	input wire logic [1:0] instruction_coupled_ram_size_o,
	input wire logic [1:0] data_coupled_ram_size_o
);
	import mmd_pkg::*;
	logic [3:0] bank;
	logic [7:0] win;
	logic rq;
	assign bank = req_addr_i[31:28];
	assign win = req_addr_i[27:20];
	assign rq = req_valid_i;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	// ====
	// assertions
	AST_ANSWER: assert property (rq |=> rsp_valid_o)
		else $error("no answer after request");
	AST_QUIET: assert property (!rq |=> !rsp_valid_o)
		else $error("answer without request");
	AST_UNUSED: assert property (rq && bank inside {[9:14]} |=>
		rsp_error_o && rsp_slave_o == MMD_SLV_ERROR)
		else $error("unused bank not refused");
	AST_EXT_CS: assert property (rq && bank inside {[1:6]} |=>
		rsp_slave_o == MMD_SLV_EXT && ext_cs_o == 6'(1 << ($past(bank) - 1)))
		else $error("wrong chip select");
	AST_EXT_HIGH: assert property (rq && bank inside {[7:8]} |=>
		rsp_slave_o == MMD_SLV_EXT && ext_cs_o == '0)
		else $error("high external bank wrong");
	AST_PERIPH: assert property (rq && bank == 4'hF |=>
		rsp_slave_o == MMD_SLV_PERIPH)
		else $error("top bank not to bridge");
	AST_ROM_FIXED: assert property (rq && req_addr_i[31:15] == 17'h00080
		|=> rsp_slave_o == MMD_SLV_ROM)
		else $error("rom missing at fixed base");
	AST_SHARED_BASE: assert property (rq && req_addr_i == 32'h00300000 &&
		instruction_coupled_ram_size_o == 2'h0 && data_coupled_ram_size_o == 2'h0 |=>
		rsp_slave_o == MMD_SLV_SRAM && rsp_block_o == 2'h3)
		else $error("shared base wrong block");
	AST_BOOT_ALIAS: assert property (rq && req_addr_i == 32'h0 &&
		!remap_o[req_master_i] |=> rsp_slave_o ==
		($past(boot_rom_o) ? MMD_SLV_ROM : MMD_SLV_EXT))
		else $error("wrong boot alias");
	AST_NONCPU: assert property (rq && bank == 4'h0 && win == 8'h00 &&
		remap_o[req_master_i] && req_master_i < MID_CPU_INSTR |=> rsp_error_o)
		else $error("alias given to non-cpu master");
	AST_RESET: assert property ($rose(rst_n_i) |-> remap_o == '0 &&
		instruction_coupled_ram_size_o == 2'h0 && data_coupled_ram_size_o == 2'h0)
		else $error("state not cleared by reset");
	AST_REMAP_SET: assert property (|remap_set_i |=>
		(remap_o & $past(remap_set_i)) == $past(remap_set_i))
		else $error("remap bit not set");
	// ====
	// covers
	COV_SHARED: cover property (rq && bank == 4'h0 && win == 8'h03);
	COV_ALIAS: cover property (rq && req_addr_i == 32'h0 && remap_o[5]);
	COV_UNUSED: cover property (rq && bank == 4'hA);
endmodule
bind mmd_decoder mmd_decoder_checker i_chk (.clock_i, .rst_n_i,
	.remap_set_i, .req_valid_i, .req_master_i, .req_addr_i, .rsp_valid_o,
	.rsp_slave_o, .rsp_error_o, .ext_cs_o, .rsp_block_o, .remap_o,
	.boot_rom_o, .instruction_coupled_ram_size_o, .data_coupled_ram_size_o);

// File: dv/mmd_decoder_tb.sv
/*
 self-checking bench for the memory map decoder.
 assumes the master model and the bound checker.
*/
`timescale 1ns/1ps
module mmd_decoder_tb;
	import mmd_pkg::*;
	localparam logic [10:0] ERR = {MMD_SLV_ERROR, 8'h00};
	logic clock_i = 1'b0, rst_n_i = 1'b0, boot = 1'b1, cfg_wr = 1'b0;
	logic go = 1'b0, tv = 1'b0, ti = 1'b0, bm = 1'b1;
	logic [5:0] rset = '0, rclr = '0, rem = '0, cs, remap;
	logic [1:0] isz_i = '0, dsz_i = '0, blk, tblk, isz_o, dsz_o;
	logic [31:0] ibase = '0, addr = '0, ta = '0, rq_a;
	logic [2:0] mid = '0, rq_m;
	logic [27:0] ofs;
	logic rv, tcm_v, tcm_hit, boot_rom, rq_v, err;
	mmd_slave_t slv;
	int isz = 0, dsz = 0, errors = 0, checked = 0;
	mmd_master_model i_mst (.clock_i(clock_i), .go_i(go), .mid_i(mid),
		.addr_i(addr), .req_valid_o(rq_v), .req_master_o(rq_m),
		.req_addr_o(rq_a));
	mmd_decoder i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.boot_select_pin_i(boot), .remap_set_i(rset), .remap_clr_i(rclr),
		.cfg_wr_i(cfg_wr), .instruction_coupled_ram_size_i(isz_i), .data_coupled_ram_size_i(dsz_i),
		.instruction_coupled_ram_base_i(ibase), .req_valid_i(rq_v), .req_master_i(rq_m),
		.req_addr_i(rq_a), .tcm_valid_i(tv), .tcm_instr_i(ti),
		.tcm_addr_i(ta), .rsp_valid_o(rv), .rsp_slave_o(slv),
		.rsp_error_o(err), .ext_cs_o(cs), .rsp_offset_o(ofs),
		.rsp_block_o(blk), .tcm_rsp_valid_o(tcm_v), .tcm_hit_o(tcm_hit),
		.tcm_block_o(tblk), .remap_o(remap), .boot_rom_o(boot_rom),
		.instruction_coupled_ram_size_o(isz_o), .data_coupled_ram_size_o(dsz_o));
	initial
		forever #12.5 clock_i = ~clock_i;
	initial
	begin
		repeat (20000) @(posedge clock_i);
		errors++;
		wrap_up();
	end
	// ====
	// helpers
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s: expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	function automatic logic [10:0] exp_f(int m, logic [31:0] a);
		int w, s, n;
		logic used;
		w = a[27:20];
		s = a[19:14];
		n = 0;
		if (a[31:28] inside {[1:6]})
			return {MMD_SLV_EXT, 6'(1 << (a[31:28] - 1)), 2'h0};
		if (a[31:28] inside {[7:8]})
			return {MMD_SLV_EXT, 8'h00};
		if (a[31:28] == 4'hF)
			return {MMD_SLV_PERIPH, 8'h00};
		if (a[31:28] != 4'h0 || w > 4)
			return ERR;
		if (w == 4 || (w == 0 && !rem[m] && bm))
			return (a[19:15] == 0) ? {MMD_SLV_ROM, 8'h00} : ERR;
		if (w == 0 && !rem[m])
			return {MMD_SLV_EXT, 8'h04};
		if (w == 0 && m < 4)
			return ERR;
		if (w == 1)
			return (s < isz) ? {MMD_SLV_SRAM, 6'h00, 2'(1 - s)} : ERR;
		if (w == 2)
			return (s < dsz) ? {MMD_SLV_SRAM, 6'h00, 2'(3 - s)} : ERR;
		for (int b = 3; b >= 0; b--)
		begin
			used = (b >= 2) ? ((3 - b) < dsz) : ((1 - b) < isz);
			if (!used && n == s)
				return {MMD_SLV_SRAM, 6'h00, 2'(b)};
			n += int'(!used);
		end
		return ERR;
	endfunction
	function automatic logic [31:0] ra();
		logic [31:0] a;
		a = $urandom;
		if (a[1:0] != 2'h0)
		begin
			a[31:16] = {9'h000, a[22:20], 4'h0};
			if (a[27:20] == 8'h00)
				a[19:14] = 6'h00;
		end
		return a;
	endfunction
	task automatic step(int m, logic [31:0] a, logic ins, int off);
		logic [10:0] e;
		int sl;
		logic [31:0] o;
		e = exp_f(m, a);
		o = (e[10:8] == MMD_SLV_ROM) ? 32'(a[14:0]) : 32'(a[27:0]);
		sl = off / 16384;
		@(negedge clock_i);
		{go, mid, addr, tv, ti} = {1'b1, 3'(m), a, 1'b1, ins};
		ta = (ins ? ibase : 32'h0) + 32'(off);
		@(posedge clock_i);
		#1;
		chk("rsp_valid", 1, 32'(rv));
		chk("slave", 32'(e[10:8]), 32'(slv));
		chk("error", 32'(e[10:8] == MMD_SLV_ERROR), 32'(err));
		chk("offset", o, 32'(ofs));
		if (e[10:8] == MMD_SLV_EXT)
			chk("ext_cs", 32'(e[7:2]), 32'(cs));
		if (e[10:8] == MMD_SLV_SRAM)
			chk("block", 32'(e[1:0]), 32'(blk));
		chk("tcm_valid", 1, 32'(tcm_v));
		chk("tcm_hit", 32'(sl < (ins ? isz : dsz)), 32'(tcm_hit));
		if (sl < (ins ? isz : dsz))
			chk("tcm_block", ins ? 1 - sl : 3 - sl, 32'(tblk));
	endtask
	task automatic idle();
		@(negedge clock_i);
		{go, tv} = 2'b00;
		@(posedge clock_i);
		#1;
		chk("rsp_valid", 0, 32'(rv));
		chk("tcm_valid", 0, 32'(tcm_v));
	endtask
	task automatic do_reset(logic b);
		@(negedge clock_i);
		{rst_n_i, boot, rem, isz, dsz, bm} = {1'b0, b, 6'h00, 64'h0, b};
		repeat (5) @(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (2) @(negedge clock_i);
		chk("boot_rom", 32'(b), 32'(boot_rom));
		chk("remap", 0, 32'(remap));
		chk("sizes", 0, 32'({isz_o, dsz_o}));
	endtask
	task automatic set_remap(logic [5:0] s, logic [5:0] c);
		@(negedge clock_i);
		{rset, rclr} = {s, c};
		@(negedge clock_i);
		{rset, rclr} = 12'h000;
		rem = (rem & ~c) | s;
		chk("remap", 32'(rem), 32'(remap));
	endtask
	task automatic cfg(logic [1:0] i, logic [1:0] d);
		@(negedge clock_i);
		{cfg_wr, isz_i, dsz_i} = {1'b1, i, d};
		ibase = {8'($urandom), 24'h000000};
		@(negedge clock_i);
		cfg_wr = 1'b0;
		isz = (i != 2'h3) ? int'(i) : isz;
		dsz = (d != 2'h3) ? int'(d) : dsz;
		chk("sizes", 32'(isz * 4 + dsz), 32'({isz_o, dsz_o}));
	endtask
	// ====
	// main sequence
	initial
	begin
		void'($urandom(17234));
		do_reset(1'b1);
		step(0, 32'h00300000, 1'b0, 0);
		step(0, 32'h00000000, 1'b0, 0);
		step(3, 32'h00407FFC, 1'b1, 0);
		step(4, 32'h00408000, 1'b0, 0);
		step(2, 32'h00500000, 1'b0, 0);
		step(0, 32'h00310000, 1'b0, 0);
		step(1, 32'h00008000, 1'b0, 0);
		step(1, 32'h90000000, 1'b0, 0);
		step(5, 32'hFFFFC000, 1'b0, 0);
		for (int b = 1; b <= 8; b++)
			step(b % 6, {4'(b), 28'h0000010}, 1'b0, 0);
		set_remap(6'h30, 6'h00);
		step(4, 32'h00000000, 1'b0, 0);
		step(0, 32'h00000000, 1'b0, 0);
		set_remap(6'h01, 6'h10);
		step(0, 32'h00000000, 1'b0, 0);
		step(4, 32'h00000000, 1'b0, 0);
		step(0, 32'h00300000, 1'b0, 0);
		for (int p = 0; p < 16; p++)
		begin
			cfg(2'(p % 4), 2'(p / 4));
			set_remap(6'($urandom), 6'($urandom));
			repeat (12)
				step($urandom_range(5), ra(), 1'($urandom),
					$urandom_range(49151));
		end
		idle();
		do_reset(1'b0);
		step(5, 32'h00000000, 1'b0, 0);
		step(4, 32'h00400000, 1'b0, 0);
		idle();
		wrap_up();
	end
endmodule
